// *** tec_capture_top.sv ***
// Transfer error capture: fault flags, mask, interrupt and error detail register
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tec_cfg.svh"

module tec_capture_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire  logic                sys_clk,
  input  wire  logic                rst_n,
  // Avalon-MM slave
  input  wire  logic [ADDR_W-1:0]   avs_address,
  input  wire  logic                avs_read,
  input  wire  logic                avs_write,
  input  wire  logic [31:0]         avs_writedata,
  input  wire  logic [3:0]          avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // Bus status channels
  input  wire  tec_pkg::tec_stat_t  rd_stat,
  input  wire  tec_pkg::tec_stat_t  wr_stat,
  // Other fault events
  input  wire  logic                request_fault_evt,
  input  wire  logic                config_address_fault_evt,
  // Interrupt
  output logic                      irq
);
  import tec_pkg::*;

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_q[1];

  // ************************************************************
  // Status arbitration
  // ************************************************************
  logic       arb_hit;
  logic [3:0] arb_fault;
  tec_opt_t   arb_opt;

  tec_fault_arbiter u_arb (
    .rd_stat (rd_stat),
    .wr_stat (wr_stat),
    .hit     (arb_hit),
    .fault   (arb_fault),
    .channel_options_word     (arb_opt)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  tec_state_t st_q;
  tec_state_t st_d;
  logic       req;
  logic       commit;
  logic       wr_commit;
  logic       hit_flag;
  logic       hit_mask;
  logic       hit_clear;
  logic       hit_detail;
  logic       mapped;
  logic [3:0] clr_vec;
  logic [3:0] set_vec;
  logic [31:0] detail_word;
  logic [31:0] rd_mux;

  always_comb begin
    req        = avs_read || avs_write;
    // A request is carried out in its second cycle, when waitrequest is low
    commit     = req && st_q.wait_n;
    wr_commit  = commit && avs_write && avs_byteenable[0];
    hit_flag   = (avs_address == `TEC_OFS_FLAG);
    hit_mask   = (avs_address == `TEC_OFS_MASK);
    hit_clear  = (avs_address == `TEC_OFS_CLEAR);
    hit_detail = (avs_address == `TEC_OFS_DETAIL);
    mapped     = hit_flag || hit_mask || hit_clear || hit_detail;

    // Reserved bits stay zero in the composed word
    detail_word = 32'h0000_0000;
    detail_word[`TEC_DET_CHAIN_BIT] = st_q.det_chain;
    detail_word[`TEC_DET_IRQEN_BIT] = st_q.det_irqen;
    detail_word[`TEC_DET_CODE_MSB:`TEC_DET_CODE_LSB] = st_q.det_code;
    detail_word[`TEC_DET_FAULT_MSB:0] = st_q.det_fault;

    rd_mux = 32'h0000_0000;
    if (hit_flag) begin
      rd_mux[3:0] = st_q.flag;
    end else if (hit_mask) begin
      rd_mux[3:0] = st_q.mask;
    end else if (hit_detail) begin
      rd_mux = detail_word;
    end

    // Both the flag register and the clear register clear by writing ones
    clr_vec = 4'h0;
    if (wr_commit && (hit_flag || hit_clear)) begin
      clr_vec = avs_writedata[3:0] & `TEC_FLG_USED;
    end

    set_vec = 4'h0;
    set_vec[`TEC_FLG_BUS] = arb_hit;
    set_vec[`TEC_FLG_REQ] = request_fault_evt;
    // Unmapped accesses count as configuration address faults
    set_vec[`TEC_FLG_CFG] = config_address_fault_evt || (commit && !mapped);

    st_d = st_q;

    // Bus handshake: one wait cycle, then the answer
    if (req && !st_q.wait_n) begin
      st_d.wait_n = 1'b1;
      st_d.rdata  = avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      st_d.wait_n = 1'b0;
    end

    // New events win over a clear in the same cycle
    st_d.flag = (st_q.flag & ~clr_vec) | set_vec;

    if (wr_commit && hit_mask) begin
      st_d.mask = avs_writedata[3:0] & `TEC_FLG_USED;
    end

    if (clr_vec[`TEC_FLG_BUS]) begin
      st_d.det_chain = 1'b0;
      st_d.det_irqen = 1'b0;
      st_d.det_code  = 6'h00;
      st_d.det_fault = 4'h0;
    end
    // Latest error overwrites; a capture in the clear cycle survives it
    if (arb_hit) begin
      st_d.det_chain = arb_opt.chain_en;
      st_d.det_irqen = arb_opt.irq_en;
      st_d.det_code  = arb_opt.code;
      st_d.det_fault = arb_fault;
    end

    st_d.irq = |(st_d.flag & st_d.mask);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q.wait_n    <= 1'b0;
      st_q.rdata     <= `TEC_RDATA_RST;
      st_q.flag      <= `TEC_FLAG_RST;
      st_q.mask      <= `TEC_MASK_RST;
      st_q.irq       <= 1'b0;
      st_q.det_chain <= 1'b0;
      st_q.det_irqen <= 1'b0;
      st_q.det_code  <= 6'h00;
      st_q.det_fault <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // The wait flag is stored inverted so that reset leaves waitrequest high
  assign avs_waitrequest = !st_q.wait_n;
  assign avs_readdata    = st_q.rdata;
  assign irq             = st_q.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_n);

  logic rd_err_a;
  logic wr_err_a;
  logic bus_clr_a;
  logic det_wr_a;

  assign rd_err_a  = rd_stat.valid && (rd_stat.kind != `TEC_KIND_NONE);
  assign wr_err_a  = wr_stat.valid && (wr_stat.kind != `TEC_KIND_NONE);
  assign bus_clr_a = clr_vec[`TEC_FLG_BUS];
  assign det_wr_a  = wr_commit && hit_detail;

  a_chain_copy: assert property (arb_hit |=> st_q.det_chain == $past(arb_opt.chain_en))
    else $error("chaining enable not captured");

  a_irqen_copy: assert property (arb_hit |=> st_q.det_irqen == $past(arb_opt.irq_en))
    else $error("completion irq enable not captured");

  a_code_copy: assert property (arb_hit |=>
      st_q.det_code == $past(arb_opt.code))
    else $error("completion code not captured");

  a_fault_nonzero: assert property (arb_hit |=> st_q.det_fault != 4'h0 &&
      st_q.det_fault == $past(arb_fault))
    else $error("fault code not stored or zero");

  a_read_alone: assert property (rd_err_a && !wr_err_a |=>
      st_q.det_fault == {`TEC_DIR_READ, $past(rd_stat.kind)} &&
      st_q.det_code == $past(rd_stat.channel_options_word.code))
    else $error("lone read fault not captured");

  a_write_prio: assert property (rd_err_a && wr_err_a |=>
      st_q.det_fault == {`TEC_DIR_WRITE, $past(wr_stat.kind)} &&
      st_q.det_code == $past(wr_stat.channel_options_word.code))
    else $error("write status did not take priority");

  a_read_codes: assert property (rd_err_a && !wr_err_a |=> st_q.det_fault[3] == 1'b0)
    else $error("read fault coded on write side");

  a_write_codes: assert property (wr_err_a |=> st_q.det_fault[3] == 1'b1 &&
      st_q.det_fault[2:0] != `TEC_KIND_NONE)
    else $error("write fault coded wrongly");

  a_bus_flag: assert property (arb_hit |=> st_q.flag[`TEC_FLG_BUS] ##1
      (st_q.flag[`TEC_FLG_BUS] || $past(bus_clr_a)))
    else $error("bus fault flag not set");

  a_bus_clear: assert property (bus_clr_a && !arb_hit |=>
      detail_word == 32'h0000_0000 && !st_q.flag[`TEC_FLG_BUS])
    else $error("bus fault clear left details");

  a_other_clear: assert property ((clr_vec[`TEC_FLG_REQ] || clr_vec[`TEC_FLG_CFG]) &&
      !bus_clr_a && !arb_hit |=> $stable(detail_word))
    else $error("other clear touched details");

  a_detail_ro: assert property (det_wr_a && !arb_hit |=> $stable(detail_word))
    else $error("write to detail register took effect");

  a_reserved_zero: assert property (detail_word[31:18] == 14'h0000 &&
      detail_word[15:14] == 2'b00 && detail_word[7:4] == 4'h0)
    else $error("reserved detail bits not zero");

  a_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0)
      !rst_sync_n |-> detail_word == 32'h0000_0000)
    else $error("detail register not zero in reset");

  a_wait_once: assert property (req && avs_waitrequest ##1 req |-> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  a_irq_level: assert property (##1 irq == |($past(st_d.flag) & $past(st_d.mask)))
    else $error("interrupt does not follow masked flags");

  c_both_faults: cover property (rd_err_a && wr_err_a);
  c_bus_clear: cover property (st_q.flag[`TEC_FLG_BUS] ##[1:20] bus_clr_a);
  c_detail_read: cover property (commit && avs_read && hit_detail && st_q.det_fault != 4'h0);
  c_irq_rise: cover property ($rose(irq));

endmodule // tec_capture_top
`default_nettype wire

// *** tec_cfg.svh ***
// Offsets, field positions, reset values and codes of the transfer error capture block
//
// Overview of operation
// - Copy failing channel's chaining enable to bit 17
// - Copy failing channel's completion irq enable to bit 16
// - Record six-bit completion code in bits 13..8
// - Store nonzero fault code in bits 3..0
// - Same-cycle statuses: capture the nonzero one
// - Both nonzero: write status wins
// - Read codes: 1,2,3,4,7; 5,6 reserved (the code captures 5 and 6 like any other nonzero kind)
// - Write codes: 9,A,B,C,F; D,E reserved (the code captures D and E like any other nonzero kind)
// - Bus error sets bus fault flag, details readable
// - Bus fault clear also clears detail register
// - Other fault clears leave detail register alone
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define TEC_OFS_FLAG       4'h0
`define TEC_OFS_MASK       4'h4
`define TEC_OFS_CLEAR      4'h8
`define TEC_OFS_DETAIL     4'hC

// ************************************************************
// Field positions
// ************************************************************
`define TEC_DET_CHAIN_BIT  17
`define TEC_DET_IRQEN_BIT  16
`define TEC_DET_CODE_MSB   13
`define TEC_DET_CODE_LSB   8
`define TEC_DET_FAULT_MSB  3
`define TEC_FLG_BUS        0
`define TEC_FLG_REQ        2
`define TEC_FLG_CFG        3
`define TEC_FLG_USED       4'hD

// ************************************************************
// Reset values
// ************************************************************
`define TEC_FLAG_RST       4'h0
`define TEC_MASK_RST       4'h0
`define TEC_RDATA_RST      32'h0000_0000

// ************************************************************
// Fault kinds; the top code bit marks the write side
// ************************************************************
`define TEC_KIND_NONE      3'h0
`define TEC_KIND_ADDR      3'h1
`define TEC_KIND_PRIV      3'h2
`define TEC_KIND_TIMEOUT   3'h3
`define TEC_KIND_DATA      3'h4
`define TEC_KIND_EXCL      3'h7
`define TEC_DIR_READ       1'b0
`define TEC_DIR_WRITE      1'b1

`endif

// *** tec_pkg.sv ***
// Types shared by the transfer error capture block
package tec_pkg;

  // Option fields of the channel that issued a transaction
  typedef struct packed {
    logic       chain_en;
    logic       irq_en;
    logic [5:0] code;
  } tec_opt_t;

  // One status channel (read or write) with its originating options
  typedef struct packed {
    logic       valid;
    logic [2:0] kind;
    tec_opt_t   channel_options_word;
  } tec_stat_t;

  // Whole state of the top module apart from the reset release flops
  typedef struct packed {
    logic        wait_n;
    logic [31:0] rdata;
    logic [3:0]  flag;
    logic [3:0]  mask;
    logic        irq;
    logic        det_chain;
    logic        det_irqen;
    logic [5:0]  det_code;
    logic [3:0]  det_fault;
  } tec_state_t;

endpackage

// *** tec_fault_arbiter.sv ***
// Picks the status channel whose fault is recorded when both report together
`timescale 1ns/1ns
`default_nettype none
`include "tec_cfg.svh"

module tec_fault_arbiter (
  // Status channels
  input  wire tec_pkg::tec_stat_t rd_stat,
  input  wire tec_pkg::tec_stat_t wr_stat,
  // Selected fault
  output var  logic               hit,
  output var  logic [3:0]         fault,
  output var  tec_pkg::tec_opt_t  channel_options_word
);
  import tec_pkg::*;

  logic rd_err;
  logic wr_err;

  always_comb begin
    rd_err = rd_stat.valid && (rd_stat.kind != `TEC_KIND_NONE);
    wr_err = wr_stat.valid && (wr_stat.kind != `TEC_KIND_NONE);
    hit    = rd_err || wr_err;
    fault  = 4'h0;
    channel_options_word    = '0;
    if (wr_err) begin
      fault = {`TEC_DIR_WRITE, wr_stat.kind};
      channel_options_word   = wr_stat.channel_options_word;
    end else if (rd_err) begin
      fault = {`TEC_DIR_READ, rd_stat.kind};
      channel_options_word   = rd_stat.channel_options_word;
    end
  end

endmodule // tec_fault_arbiter
`default_nettype wire

// *** tec_status_model.sv ***
// Behavioural model of the system bus read and write status channels
`timescale 1ns/1ns
`default_nettype none

module tec_status_model
  import tec_pkg::*;
(
  // Clock and command from the bench
  input  wire logic                sys_clk,
  input  wire logic                fire,
  input  wire tec_pkg::tec_stat_t  rd_req,
  input  wire tec_pkg::tec_stat_t  wr_req,
  // Status channels towards the block
  output var  tec_pkg::tec_stat_t  rd_stat,
  output var  tec_pkg::tec_stat_t  wr_stat
);
  initial begin
    rd_stat = '0;
    wr_stat = '0;
  end

  // Between pulses the fields flip every cycle, so a stale capture shows up
  always @(posedge sys_clk) begin
    if (fire) begin
      rd_stat <= rd_req;
      wr_stat <= wr_req;
    end else begin
      rd_stat <= {1'b0, ~rd_stat.kind, ~rd_stat.channel_options_word};
      wr_stat <= {1'b0, ~wr_stat.kind, ~wr_stat.channel_options_word};
    end
  end
endmodule // tec_status_model

`default_nettype wire

// *** transfer_error_capture_tb.sv ***
// Self-checking bench for the transfer error capture block
`timescale 1ns/1ns
`default_nettype none
`include "tec_cfg.svh"

module transfer_error_capture_tb;
  import tec_pkg::*;
  logic        sys_clk         = 1'b0;
  logic        rst_n           = 1'b0;
  logic [3:0]  avs_address     = 4'h0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [3:0]  avs_byteenable  = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  tec_stat_t   rd_req          = '0;
  tec_stat_t   wr_req          = '0;
  tec_stat_t   rd_stat;
  tec_stat_t   wr_stat;
  logic        fire            = 1'b0;
  logic        req_evt         = 1'b0;
  logic        cfg_evt         = 1'b0;
  logic        irq;
  logic [31:0] q;
  logic [31:0] hold;
  tec_opt_t    o;
  int          n_errors        = 0;
  int          n_compared      = 0;
  // ************************************************************
  // Rows: read kind, write kind, expected fault code
  // ************************************************************
  logic [2:0]  rk [12] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h7};
  logic [2:0]  wk [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h3, 3'h7};
  logic [3:0]  ef [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF, 4'hB, 4'hF};

  always #5 sys_clk = ~sys_clk;

  tec_status_model tec_status_model_i (.sys_clk(sys_clk), .fire(fire), .rd_req(rd_req),
    .wr_req(wr_req), .rd_stat(rd_stat), .wr_stat(wr_stat));

  tec_capture_top #(.ADDR_W(4)) tec_capture_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_stat(rd_stat),
    .wr_stat(wr_stat), .request_fault_evt(req_evt), .config_address_fault_evt(cfg_evt),
    .irq(irq));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; ends one idle edge after release
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) begin
      n_errors++;
      $display("ERROR bus answer expected within 50 seen none");
      tally_and_finish();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic evt(input tec_stat_t r, input tec_stat_t w);
    rd_req <= r;
    wr_req <= w;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] det(input tec_opt_t p, input logic [3:0] f);
    return {14'h0, p.chain_en, p.irq_en, 2'b00, p.code, 4'h0, f};
  endfunction

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
    chk("detail after reset", 32'h0000_0000, q);
    bus(1'b1, `TEC_OFS_MASK, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      o = '{chain_en: i[0], irq_en: i[1], code: 6'(i * 5 + 8)};
      evt({1'b1, rk[i], o}, {1'b1, wk[i], ~o});
      chk("irq", 32'h0000_0001, {31'h0, irq});
      bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
      chk("detail", det(ef[i][3] ? ~o : o, ef[i]), q);
      bus(1'b0, `TEC_OFS_FLAG, 32'h0);
      chk("flag", 32'h0000_0001, q);
      bus(1'b1, `TEC_OFS_CLEAR, 32'h0000_0001);
      bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
      chk("detail cleared", 32'h0000_0000, q);
    end
    o = '{chain_en: 1'b1, irq_en: 1'b1, code: 6'h3F};
    evt({1'b1, 3'h0, ~o}, {1'b1, 3'h4, o});
    hold = det(o, 4'hC);
    bus(1'b1, `TEC_OFS_DETAIL, 32'hFFFF_FFFF);
    bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
    chk("detail after write", hold, q);
    req_evt <= 1'b1;
    cfg_evt <= 1'b1;
    @(posedge sys_clk);
    req_evt <= 1'b0;
    cfg_evt <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, `TEC_OFS_FLAG, 32'h0);
    chk("flag three", 32'h0000_000D, q);
    bus(1'b1, `TEC_OFS_CLEAR, 32'h0000_000C);
    bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
    chk("detail kept", hold, q);
    avs_byteenable <= 4'h0;
    bus(1'b1, `TEC_OFS_CLEAR, 32'h0000_0001);
    avs_byteenable <= 4'hF;
    bus(1'b0, `TEC_OFS_FLAG, 32'h0);
    chk("flag no lane", 32'h0000_0001, q);
    bus(1'b1, `TEC_OFS_MASK, 32'h0000_0000);
    @(posedge sys_clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    bus(1'b1, `TEC_OFS_FLAG, 32'h0000_0001);
    bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
    chk("detail flag clear", 32'h0000_0000, q);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped read", 32'h0000_0000, q);
    bus(1'b0, `TEC_OFS_FLAG, 32'h0);
    chk("flag unmapped", 32'h0000_0008, q);
    evt({1'b1, 3'h2, o}, '0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `TEC_OFS_DETAIL, 32'h0);
    chk("detail second reset", 32'h0000_0000, q);
    tally_and_finish();
  end
endmodule // transfer_error_capture_tb

`default_nettype wire
